// *** include/pcgo_pkg.sv ***
// Shared constants, register map and field layout of the clock control block
package pcgo_pkg;
    // Register byte offsets
    localparam logic [7:0] SYS_SET_OFS   = 8'h00;
    localparam logic [7:0] SYS_CLR_OFS   = 8'h04;
    localparam logic [7:0] SYS_STATE_OFS = 8'h08;
    localparam logic [7:0] PER_SET_OFS   = 8'h10;
    localparam logic [7:0] PER_CLR_OFS   = 8'h14;
    localparam logic [7:0] PER_STATE_OFS = 8'h18;
    localparam logic [7:0] OSC_CFG_OFS   = 8'h20;
    localparam logic [7:0] FREQ_OFS      = 8'h24;
    localparam logic [7:0] PLL_CFG_OFS   = 8'h2C;
    localparam logic [7:0] MST_CFG_OFS   = 8'h30;
    localparam logic [7:0] OUT0_CFG_OFS  = 8'h40;
    localparam logic [7:0] OUT1_CFG_OFS  = 8'h44;
    localparam logic [7:0] OUT2_CFG_OFS  = 8'h48;
    localparam logic [7:0] IRQ_SET_OFS   = 8'h60;
    localparam logic [7:0] IRQ_CLR_OFS   = 8'h64;
    localparam logic [7:0] STATUS_OFS    = 8'h68;
    localparam logic [7:0] IRQ_MASK_OFS  = 8'h6C;

    // Number of programmable clock outputs
    localparam int NUM_OUT = 3;
    // Bit of output 0 in the system clock set/clear/state registers
    localparam int SYS_OUT_LSB = 8;

    // Clock source encodings (2 is reserved and acts as slow clock)
    localparam logic [1:0] SRC_SLOW = 2'h0;
    localparam logic [1:0] SRC_MAIN = 2'h1;
    localparam logic [1:0] SRC_PLL  = 2'h3;

    // Source / scale field layout in master and output config registers
    localparam int SRC_LSB   = 0;
    localparam int SCALE_LSB = 2;

    // Oscillator config layout
    localparam int OSC_ON_BIT    = 0;
    localparam int STARTUP_LSB   = 8;
    localparam int OSC_MULT_SHFT = 3;   // Start-up time is 8 x count slow cycles

    // PLL config layout and reset value
    localparam int PLL_DIV_LSB    = 0;
    localparam int PLL_SETTLE_LSB = 8;
    localparam int PLL_FACTOR_LSB = 16;
    localparam int PLL_USB_LSB    = 28;
    localparam logic [5:0] PLL_SETTLE_RST = 6'h3F;

    // Frequency count layout
    localparam int FREQ_DONE_BIT = 16;
    localparam logic [4:0] FREQ_WINDOW = 5'h10;   // Sixteen slow clock cycles

    // Status register bits
    localparam int ST_OSC_BIT = 0;
    localparam int ST_PLL_BIT = 2;
    localparam int ST_MST_BIT = 3;
    localparam int ST_OUT_LSB = 8;

    // Slow clock cycles a master switch takes once the target runs
    localparam logic [2:0] MST_SWITCH_SLOW = 3'h5;
endpackage : pcgo_pkg

// *** core/pcgo_top.sv ***
// Clock control block: peripheral gates, clock outputs, oscillator, PLL, master clock
//
// Behaviour
// - Separate gate per peripheral, set/clear/state registers
// - Gate off takes effect immediately
// - All peripheral gates off after reset
// - Gate bit position equals peripheral identifier
// - Three independent programmable clock outputs
// - Output source slow, PLL or main; slow default
// - Output divided by power of two 1..64; scale 7 here divides by 128
// - System set/clear bits turn outputs on/off
// - Per-output ready flag once output matches programming
// - Oscillator enable clears stable; set after 8xcount
// - Count main cycles over sixteen slow cycles
// - PLL divider 0..255, zero switches off; here divider zero does not block the settled flag, only factor zero does
// - PLL factor 0..2047, zero switches PLL off
// - Each PLL write counts settle cycles before settled
// - Factor or divider change clears settled flag
// - USB ratio field selects divide 1, 2, 4
// - Master source and scale fields, slow default
// - Master change clears ready until established
// - Unsettled PLL master falls back to main clock
// - Flags raise interrupt when enabled
// - Settle counter decrements per slow cycle to zero
//
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module pcgo_top
    import pcgo_pkg::*;
#(
    parameter logic [31:0] PERIPH_IMPL = 32'hFFFFFFFC    // Implemented peripheral identifiers
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              slow_clock,
    input  wire logic              main_clock,
    input  wire logic              pll_clock,
    output logic [31:0]            periph_clk_en,
    output logic [NUM_OUT-1:0]     clock_output_n,
    output logic                   oscillator_on,
    output logic [7:0]             pll_div,
    output logic [10:0]            pll_factor,
    output logic [1:0]             usb_ratio_field,
    output logic [1:0]             master_source,
    output logic [2:0]             master_scale,
    output logic                   pcgo_irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Parameter check
    if (PERIPH_IMPL == 32'h0000_0000) begin : g_bad_impl
        $error("pcgo_top: no peripheral identifier implemented");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [2:0]                 sync1;      // 0 slow, 1 main, 2 PLL
        logic [2:0]                 sync2;
        logic [2:0]                 prev;
        logic                       bus_pend;
        logic                       bus_write;
        logic [7:0]                 bus_addr;
        logic [31:0]                rdata;
        logic                       rdy;
        logic [31:0]                periph;
        logic [NUM_OUT-1:0]         out_en;
        logic [NUM_OUT-1:0][1:0]    out_src;
        logic [NUM_OUT-1:0][2:0]    out_scale;
        logic [NUM_OUT-1:0][6:0]    out_cnt;
        logic [NUM_OUT-1:0]         out_lvl;
        logic [NUM_OUT-1:0]         out_rdy;
        logic                       osc_on;
        logic [7:0]                 startup;
        logic [10:0]                osc_cnt;
        logic                       osc_stable;
        logic                       freq_run;
        logic                       freq_done;
        logic [4:0]                 freq_slow;
        logic [15:0]                freq_val;
        logic [7:0]                 div;
        logic [5:0]                 settle;
        logic [10:0]                factor;
        logic [1:0]                 usb;
        logic [5:0]                 pll_cnt;
        logic                       pll_busy;
        logic                       pll_settled;
        logic [1:0]                 mst_src;
        logic [2:0]                 mst_scale;
        logic [1:0]                 mst_eff;
        logic [2:0]                 mst_cnt;
        logic                       mst_busy;
        logic                       mst_ready;
        logic [15:0]                irq_mask;
        logic                       irq;
    } pcgo_state_type;

    pcgo_state_type state_ff;
    pcgo_state_type nxt_state;

    ////////////////////////////////////////////////////////////////////////////////
    // Functions

    // Level of the chosen source; the reserved code acts as slow clock
    function automatic logic pcgo_pick(input logic [2:0] lvl, input logic [1:0] src);
        logic r;
        r = lvl[0];
        if (src == SRC_MAIN) begin
            r = lvl[1];
        end else if (src == SRC_PLL) begin
            r = lvl[2];
        end
        return r;
    endfunction : pcgo_pick

    // Power-of-two division: scale k taps counter bit k-1, scale 0 passes through
    function automatic logic pcgo_scaled(input logic lvl, input logic [6:0] cnt,
                                         input logic [2:0] sc);
        logic r;
        r = lvl;
        if (sc != 3'h0) begin
            r = cnt[sc - 3'h1];
        end
        return r;
    endfunction : pcgo_scaled

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic [2:0]  rise;
        logic        wr;
        logic [31:0] wd;
        logic [31:0] rd;
        logic [15:0] flags;
        logic [1:0]  want;
        logic        pll_lost;
        logic        lvl;
        rise      = 3'h0;
        wr        = 1'b0;
        wd        = hwdata;
        rd        = 32'h0000_0000;
        flags     = 16'h0000;
        want      = SRC_SLOW;
        pll_lost  = 1'b0;
        lvl       = 1'b0;
        nxt_state = state_ff;

        nxt_state.sync1 = {pll_clock, main_clock, slow_clock};
        nxt_state.sync2 = state_ff.sync1;
        nxt_state.prev  = state_ff.sync2;
        rise = state_ff.sync2 & ~state_ff.prev;

        // Bus: one wait state, data phase completes two edges after address phase
        nxt_state.rdy      = 1'b1;
        nxt_state.bus_pend = 1'b0;
        if (hsel && htrans[1] && hready && state_ff.rdy) begin
            nxt_state.bus_pend  = 1'b1;
            nxt_state.bus_write = hwrite;
            nxt_state.bus_addr  = haddr[7:0];
            nxt_state.rdy       = 1'b0;
        end
        wr = state_ff.bus_pend && state_ff.bus_write;

        // Status flags, all generated on ref_clk from synchronised levels
        flags[ST_OSC_BIT] = state_ff.osc_stable;
        flags[ST_PLL_BIT] = state_ff.pll_settled;
        flags[ST_MST_BIT] = state_ff.mst_ready;
        flags[ST_OUT_LSB +: NUM_OUT] = state_ff.out_rdy;

        // Read mux; unmapped offsets read zero
        unique case (state_ff.bus_addr)
            SYS_STATE_OFS: rd[SYS_OUT_LSB +: NUM_OUT] = state_ff.out_en;
            PER_STATE_OFS: rd = state_ff.periph;
            OSC_CFG_OFS: begin
                rd[OSC_ON_BIT]          = state_ff.osc_on;
                rd[STARTUP_LSB +: 8]    = state_ff.startup;
            end
            FREQ_OFS: begin
                rd[FREQ_DONE_BIT] = state_ff.freq_done;
                rd[15:0]          = state_ff.freq_val;
            end
            PLL_CFG_OFS: begin
                rd[PLL_DIV_LSB +: 8]    = state_ff.div;
                rd[PLL_SETTLE_LSB +: 6] = state_ff.settle;
                rd[PLL_FACTOR_LSB +: 11] = state_ff.factor;
                rd[PLL_USB_LSB +: 2]    = state_ff.usb;
            end
            MST_CFG_OFS: begin
                rd[SRC_LSB +: 2]   = state_ff.mst_src;
                rd[SCALE_LSB +: 3] = state_ff.mst_scale;
            end
            OUT0_CFG_OFS, OUT1_CFG_OFS, OUT2_CFG_OFS: begin
                for (int i = 0; i < NUM_OUT; i++) begin
                    if (state_ff.bus_addr[3:2] == 2'(i)) begin
                        rd[SRC_LSB +: 2]   = state_ff.out_src[i];
                        rd[SCALE_LSB +: 3] = state_ff.out_scale[i];
                    end
                end
            end
            STATUS_OFS:   rd[15:0] = flags;
            IRQ_MASK_OFS: rd[15:0] = state_ff.irq_mask;
            default:      rd = 32'h0000_0000;
        endcase
        if (state_ff.bus_pend && !state_ff.bus_write) begin
            nxt_state.rdata = rd;
        end

        if (wr && state_ff.bus_addr == PER_SET_OFS) begin
            nxt_state.periph = state_ff.periph | (wd & PERIPH_IMPL);
        end
        // clear lands on the next edge
        if (wr && state_ff.bus_addr == PER_CLR_OFS) begin
            nxt_state.periph = state_ff.periph & ~(wd & PERIPH_IMPL);
        end

        for (int i = 0; i < NUM_OUT; i++) begin
            // output on/off, ready drops on disable
            if (wr && state_ff.bus_addr == SYS_SET_OFS && wd[SYS_OUT_LSB + i]) begin
                nxt_state.out_en[i] = 1'b1;
            end
            if (wr && state_ff.bus_addr == SYS_CLR_OFS && wd[SYS_OUT_LSB + i]) begin
                nxt_state.out_en[i]  = 1'b0;
                nxt_state.out_rdy[i] = 1'b0;
            end
            if (wr && state_ff.bus_addr == (OUT0_CFG_OFS + 8'(4 * i))) begin
                nxt_state.out_src[i]   = wd[SRC_LSB +: 2];
                nxt_state.out_scale[i] = wd[SCALE_LSB +: 3];
                nxt_state.out_rdy[i]   = 1'b0;
            end
            lvl = pcgo_pick(state_ff.sync2, state_ff.out_src[i]);
            if (pcgo_pick(rise, state_ff.out_src[i])) begin
                nxt_state.out_cnt[i] = state_ff.out_cnt[i] + 7'h01;
                // ready on first source edge while enabled
                if (state_ff.out_en[i]) begin
                    nxt_state.out_rdy[i] = 1'b1;
                end
            end
            nxt_state.out_lvl[i] = state_ff.out_en[i]
                                 & pcgo_scaled(lvl, state_ff.out_cnt[i], state_ff.out_scale[i]);
        end

        // oscillator start-up timer, 8 slow cycles per count
        if (state_ff.osc_on && !state_ff.osc_stable && rise[0]) begin
            if (state_ff.osc_cnt == 11'h000) begin
                nxt_state.osc_stable = 1'b1;
            end else begin
                nxt_state.osc_cnt = state_ff.osc_cnt - 11'h001;
            end
        end
        if (wr && state_ff.bus_addr == OSC_CFG_OFS) begin
            nxt_state.osc_on     = wd[OSC_ON_BIT];
            nxt_state.startup    = wd[STARTUP_LSB +: 8];
            nxt_state.osc_cnt    = {wd[STARTUP_LSB +: 8], 3'h0};
            nxt_state.osc_stable = 1'b0;
            nxt_state.freq_done  = 1'b0;
            nxt_state.freq_run   = 1'b0;
        end

        // main cycles over sixteen slow cycles
        if (state_ff.osc_stable && !state_ff.freq_done) begin
            if (!state_ff.freq_run && rise[0]) begin
                nxt_state.freq_run  = 1'b1;
                nxt_state.freq_slow = 5'h00;
                nxt_state.freq_val  = 16'h0000;
            end else if (state_ff.freq_run) begin
                if (rise[1]) begin
                    nxt_state.freq_val = state_ff.freq_val + 16'h0001;
                end
                if (rise[0]) begin
                    nxt_state.freq_slow = state_ff.freq_slow + 5'h01;
                    if (state_ff.freq_slow == FREQ_WINDOW - 5'h01) begin
                        nxt_state.freq_run  = 1'b0;
                        nxt_state.freq_done = 1'b1;
                    end
                end
            end
        end

        // settle counter runs down on slow edges
        if (state_ff.pll_busy && rise[0]) begin
            if (state_ff.pll_cnt == 6'h00) begin
                nxt_state.pll_busy = 1'b0;
            end else begin
                nxt_state.pll_cnt = state_ff.pll_cnt - 6'h01;
            end
        end
        // factor zero keeps the PLL off
        if (state_ff.pll_busy && state_ff.pll_cnt == 6'h00 && rise[0]
            && state_ff.factor != 11'h000) begin
            nxt_state.pll_settled = 1'b1;
        end
        if (wr && state_ff.bus_addr == PLL_CFG_OFS) begin
            nxt_state.div    = wd[PLL_DIV_LSB +: 8];
            nxt_state.settle = wd[PLL_SETTLE_LSB +: 6];
            nxt_state.factor = wd[PLL_FACTOR_LSB +: 11];
            nxt_state.usb    = wd[PLL_USB_LSB +: 2];
            nxt_state.pll_cnt  = wd[PLL_SETTLE_LSB +: 6];
            nxt_state.pll_busy = 1'b1;
            if (wd[PLL_FACTOR_LSB +: 11] != state_ff.factor
                || wd[PLL_DIV_LSB +: 8] != state_ff.div
                || wd[PLL_FACTOR_LSB +: 11] == 11'h000) begin
                nxt_state.pll_settled = 1'b0;
            end
        end

        if (wr && state_ff.bus_addr == MST_CFG_OFS) begin
            nxt_state.mst_src   = wd[SRC_LSB +: 2];
            nxt_state.mst_scale = wd[SCALE_LSB +: 3];
            if (wd[SRC_LSB +: 2] != state_ff.mst_src
                || wd[SCALE_LSB +: 3] != state_ff.mst_scale) begin
                nxt_state.mst_ready = 1'b0;
                nxt_state.mst_busy  = 1'b1;
                nxt_state.mst_cnt   = MST_SWITCH_SLOW;
            end
        end
        // fall back to main while PLL unsettled
        pll_lost = (state_ff.mst_src == SRC_PLL) && !state_ff.pll_settled;
        want     = pll_lost ? SRC_MAIN : state_ff.mst_src;
        if (want != state_ff.mst_eff) begin
            nxt_state.mst_eff   = want;
            nxt_state.mst_ready = 1'b0;
            nxt_state.mst_busy  = 1'b1;
            nxt_state.mst_cnt   = MST_SWITCH_SLOW;
        end else if (state_ff.mst_busy && rise[0]) begin
            if (state_ff.mst_cnt != 3'h0) begin
                nxt_state.mst_cnt = state_ff.mst_cnt - 3'h1;
            end else if (!pll_lost) begin
                nxt_state.mst_busy  = 1'b0;
                nxt_state.mst_ready = 1'b1;
            end
        end
        if (pll_lost) begin
            nxt_state.mst_ready = 1'b0;
        end

        // enabled flags raise the interrupt line
        if (wr && state_ff.bus_addr == IRQ_SET_OFS) begin
            nxt_state.irq_mask = state_ff.irq_mask | wd[15:0];
        end
        if (wr && state_ff.bus_addr == IRQ_CLR_OFS) begin
            nxt_state.irq_mask = state_ff.irq_mask & ~wd[15:0];
        end
        nxt_state.irq = |(flags & state_ff.irq_mask);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_ff          <= '0;
            state_ff.rdy      <= 1'b1;
            state_ff.settle   <= PLL_SETTLE_RST;
            state_ff.mst_ready <= 1'b1;      // Slow clock is running from reset
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from the state register except the constant hresp
    assign hrdata          = state_ff.rdata;
    assign hreadyout       = state_ff.rdy;
    assign hresp           = 1'b0;               // Always OKAY
    assign periph_clk_en   = state_ff.periph;
    assign clock_output_n  = state_ff.out_lvl;
    assign oscillator_on   = state_ff.osc_on;
    assign pll_div         = state_ff.div;
    assign pll_factor      = state_ff.factor;
    assign usb_ratio_field = state_ff.usb;
    assign master_source   = state_ff.mst_eff;   // Effective source, includes fallback
    assign master_scale    = state_ff.mst_scale;
    assign pcgo_irq        = state_ff.irq;

endmodule : pcgo_top

// *** bench/pcgo_checker.sv ***
// Port-level assertions for the clock control block
`timescale 1ns/1ps
module pcgo_checker
    import pcgo_pkg::*;
#(
    parameter logic [31:0] PERIPH_IMPL = 32'hFFFFFFFC
) (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] periph_clk_en,
    input wire logic        oscillator_on,
    input wire logic [7:0]  pll_div,
    input wire logic [10:0] pll_factor,
    input wire logic [1:0]  usb_ratio_field,
    input wire logic [1:0]  master_source,
    input wire logic [2:0]  master_scale,
    input wire logic        pcgo_irq
);
    logic [7:0] wofs_ff;
    logic [1:0] age_ff;
    // Last write target and its age, so register outputs can be traced to a write
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wofs_ff <= 8'hFF;
            age_ff  <= 2'h3;
        end else if (hsel && htrans[1] && hready && hreadyout) begin
            wofs_ff <= hwrite ? haddr[7:0] : 8'hFF;
            age_ff  <= 2'h0;
        end else if (age_ff != 2'h3) begin
            age_ff <= age_ff + 2'h1;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_taken; hsel && htrans[1] && hready && hreadyout; endsequence
    sequence s_wait; !hreadyout ##1 hreadyout; endsequence
    chk_one_wait: assert property (s_taken |=> s_wait)
        else $error("transfer wait is not one cycle");
    chk_resp_okay: assert property (!hresp)
        else $error("response is not OKAY");
    chk_gate_rise: assert property (
        |(periph_clk_en & ~$past(periph_clk_en)) |-> wofs_ff == PER_SET_OFS && age_ff == 2'h1)
        else $error("gate turned on without a set write");
    chk_gate_fall: assert property (
        |(~periph_clk_en & $past(periph_clk_en)) |-> wofs_ff == PER_CLR_OFS && age_ff == 2'h1)
        else $error("gate turned off without a prompt clear write");
    chk_gate_impl: assert property ((periph_clk_en & ~PERIPH_IMPL) == 32'h0)
        else $error("unimplemented gate is on");
    chk_gate_reset: assert property ($fell(rst) |-> periph_clk_en == 32'h0)
        else $error("gate on after reset");
    chk_pll_fields: assert property (
        !$stable({pll_div, pll_factor, usb_ratio_field})
        |-> wofs_ff == PLL_CFG_OFS && age_ff == 2'h1)
        else $error("pll fields moved without a pll write");
    chk_osc_write: assert property (
        !$stable(oscillator_on) |-> wofs_ff == OSC_CFG_OFS && age_ff == 2'h1)
        else $error("oscillator enable moved without a write");
    chk_scale_write: assert property (
        !$stable(master_scale) |-> wofs_ff == MST_CFG_OFS && age_ff == 2'h1)
        else $error("master scale moved without a write");
    chk_master_reset: assert property (
        $fell(rst) |-> master_source == SRC_SLOW && master_scale == 3'h0 && !pcgo_irq)
        else $error("master or interrupt not at reset value");
endmodule : pcgo_checker

// *** bench/test_power_clock_gating_and_outputs.sv ***
// Self-checking bench for the clock control block
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin mismatches++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end end
module test_power_clock_gating_and_outputs
    import pcgo_pkg::*;
;
    logic        ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata, periph_clk_en;
    logic [1:0]  htrans = 2'h0, usb_ratio_field, master_source;
    logic [4:0]  div_cnt = 5'h0;
    logic        slow_clock = 1'b0, main_clock = 1'b0, pll_clock = 1'b0;
    logic        hreadyout, hresp, oscillator_on, pcgo_irq;
    logic [2:0]  clock_output_n, master_scale, prev;
    logic [7:0]  pll_div;
    logic [10:0] pll_factor;
    int          mismatches = 0, comparisons = 0, rises [3];
    time         t0;
    logic [7:0]  rst_ofs [9] = '{SYS_STATE_OFS, PER_STATE_OFS, OSC_CFG_OFS, FREQ_OFS,
                                 PLL_CFG_OFS, MST_CFG_OFS, OUT0_CFG_OFS, STATUS_OFS, 8'h0C};
    logic [31:0] rst_val [9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h3F00, 32'h0, 32'h0, 32'h8, 32'h0};
    logic [1:0]  srcs [3] = '{SRC_SLOW, SRC_MAIN, SRC_PLL};
    int          exp_r [3] = '{10, 20, 5};
    pcgo_top dut (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .slow_clock, .main_clock, .pll_clock,
        .periph_clk_en, .clock_output_n, .oscillator_on, .pll_div, .pll_factor,
        .usb_ratio_field, .master_source, .master_scale, .pcgo_irq);
    always #50 ref_clk = ~ref_clk;
    // Source clocks from one counter; the slow clock is shortened to keep the run brief
    always @(posedge ref_clk) begin
        div_cnt <= div_cnt + 5'h1;
        slow_clock <= div_cnt[3];
        main_clock <= div_cnt[1];
        pll_clock <= div_cnt[2];
    end
    // One single AHB transfer; waits on the slave's ready, read data taken at the last edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK($sformatf("reg %h", a), e, rd)
    endtask : chk_rd
    // Bounded poll of one status bit; the task itself checks the final value
    task automatic poll(input logic [7:0] a, input int b);
        int n;
        n = 0;
        do begin
            bus(1'b0, a, 32'h0);
            n++;
        end while (rd[b] !== 1'b1 && n < 400);
        `CHK($sformatf("bit %0d of %h", b, a), 1'b1, rd[b])
    endtask : poll
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results
    // Watchdog well beyond the expected few thousand cycles
    initial begin
        #3_000_000;
        mismatches++;
        results();
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (rst_ofs[i])
            chk_rd(rst_ofs[i], rst_val[i]);
        bus(1'b1, PER_SET_OFS, 32'h00000113);
        chk_rd(PER_STATE_OFS, 32'h00000110);
        `CHK("periph_clk_en", 32'h00000110, periph_clk_en)
        bus(1'b1, PER_CLR_OFS, 32'h00000010);
        `CHK("periph_clk_en", 32'h00000100, periph_clk_en)
        bus(1'b1, PER_SET_OFS, 32'hFFFFFFFF);
        chk_rd(PER_STATE_OFS, 32'hFFFFFFFC);
        bus(1'b1, PER_CLR_OFS, 32'hFFFFFFFF);
        chk_rd(PER_STATE_OFS, 32'h0);
        // Start-up count of 2 gives 16 slow cycles plus synchroniser slack
        t0 = $time;
        bus(1'b1, OSC_CFG_OFS, 32'h00000201);
        `CHK("oscillator_on", 1'b1, oscillator_on)
        chk_rd(STATUS_OFS, 32'h8);
        poll(STATUS_OFS, ST_OSC_BIT);
        `CHK("osc time", 1'b1, ($time - t0) / 100 inside {[240:300]})
        poll(FREQ_OFS, FREQ_DONE_BIT);
        `CHK("freq value", 1'b1, rd[15:0] inside {[62:66]})
        bus(1'b1, IRQ_SET_OFS, 32'h1);
        chk_rd(IRQ_MASK_OFS, 32'h1);
        `CHK("pcgo_irq", 1'b1, pcgo_irq)
        bus(1'b1, IRQ_CLR_OFS, 32'h1);
        repeat (2) @(posedge ref_clk);
        `CHK("pcgo_irq", 1'b0, pcgo_irq)
        // Each write changes the factor, so settling restarts from a count of 4
        for (int u = 0; u < 3; u++) begin
            t0 = $time;
            bus(1'b1, PLL_CFG_OFS, {2'h0, u[1:0], 1'b0, 11'(4 + u), 2'h0, 6'h04, 8'h01});
            `CHK("usb_ratio_field", u[1:0], usb_ratio_field)
            `CHK("pll_factor", 11'(4 + u), pll_factor)
            `CHK("pll_div", 8'h01, pll_div)
            chk_rd(STATUS_OFS, 32'h9);
            poll(STATUS_OFS, ST_PLL_BIT);
            `CHK("settle time", 1'b1, ($time - t0) / 100 inside {[64:112]})
        end
        // Scale first, then the PLL source, each followed by a ready wait
        bus(1'b1, MST_CFG_OFS, {27'h0, 3'h4, SRC_SLOW});
        chk_rd(STATUS_OFS, 32'h5);
        poll(STATUS_OFS, ST_MST_BIT);
        `CHK("master_scale", 3'h4, master_scale)
        bus(1'b1, MST_CFG_OFS, {27'h0, 3'h4, SRC_PLL});
        poll(STATUS_OFS, ST_MST_BIT);
        `CHK("master_source", SRC_PLL, master_source)
        bus(1'b1, PLL_CFG_OFS, 32'h10080401);
        chk_rd(STATUS_OFS, 32'h1);
        `CHK("master_source", SRC_MAIN, master_source)
        poll(STATUS_OFS, ST_MST_BIT);
        `CHK("master_source", SRC_PLL, master_source)
        // Outputs configured while disabled, since the output path has no glitch guard
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, OUT0_CFG_OFS + 8'(i * 4), {27'h0, 3'(i + 1), srcs[i]});
            chk_rd(OUT0_CFG_OFS + 8'(i * 4), {27'h0, 3'(i + 1), srcs[i]});
        end
        bus(1'b1, SYS_SET_OFS, 32'h00000700);
        chk_rd(SYS_STATE_OFS, 32'h00000700);
        for (int i = 0; i < 3; i++)
            poll(STATUS_OFS, ST_OUT_LSB + i);
        rises = '{0, 0, 0};
        repeat (320) begin
            prev = clock_output_n;
            @(posedge ref_clk);
            for (int i = 0; i < 3; i++)
                rises[i] += int'(clock_output_n[i] && !prev[i]);
        end
        for (int i = 0; i < 3; i++)
            `CHK("output rises", 1'b1, rises[i] inside {[exp_r[i] - 1:exp_r[i] + 1]})
        bus(1'b1, SYS_CLR_OFS, 32'h00000700);
        chk_rd(SYS_STATE_OFS, 32'h0);
        `CHK("clock_output_n", 3'h0, clock_output_n)
        results();
    end
endmodule : test_power_clock_gating_and_outputs
bind pcgo_top pcgo_checker #(.PERIPH_IMPL(PERIPH_IMPL)) u_chk (.ref_clk, .rst, .hsel, .haddr,
    .htrans, .hwrite, .hready, .hreadyout, .hresp, .periph_clk_en, .oscillator_on, .pll_div,
    .pll_factor, .usb_ratio_field, .master_source, .master_scale, .pcgo_irq);
